// file: rtl/fdu_pkg.sv
// package of constants and types for the fault dispatch unit
package fdu_pkg;
  localparam int WORD_W = 32;
  // register offsets on the bus
  localparam logic [7:0] OFF_CTRL = 8'h00;      // control: no-imprecise bit, mode, table trace flag
  localparam logic [7:0] OFF_FAULT = 8'h04;     // fault request: type/subtype/kind
  localparam logic [7:0] OFF_SSP = 8'h08;       // supervisor stack pointer from table
  localparam logic [7:0] OFF_HIP = 8'h0C;       // handler ip from table
  localparam logic [7:0] OFF_FP = 8'h10;        // current frame pointer
  localparam logic [7:0] OFF_STATUS = 8'h14;    // dispatch status (read)
  localparam logic [7:0] OFF_NFP = 8'h18;       // new frame pointer (read)
  localparam logic [7:0] OFF_REC = 8'h1C;       // fault record word (read)
  localparam logic [7:0] OFF_OVR = 8'h20;       // override type/subtype/data (read)
  localparam logic [7:0] OFF_ACPC = 8'h24;      // arith/process controls (read)
  localparam logic [7:0] OFF_RET = 8'h28;       // write: handler return
  localparam logic [7:0] OFF_ERRADDR = 8'h2C;   // address bus image (read)
  // field positions and constants
  localparam int CTRL_NIF = 0;
  localparam int CTRL_USER = 1;
  localparam int CTRL_TTRACE = 2;
  localparam int CTRL_IRQ = 3;
  localparam int CTRL_SYNC = 4;
  localparam int TRACE_ENABLE_BIT = 0;
  localparam int PC_TFP = 1;
  localparam int PC_USER = 2;
  localparam logic [2:0] FAULT_RET_CODE = 3'b001;
  localparam logic [7:0] TT_TRACE_FLAG_BYTE = 8'h0C;  // table trace flag sits at byte 12 bit 0
  localparam logic [31:0] SYS_ERR_ADDR = 32'hFEFFFF68;
  localparam logic [31:0] RECORD_SIZE = 32'h00000030;
  localparam logic [7:0] FT_TRACE = 8'h01;
  localparam logic [7:0] FT_OPER = 8'h02;
  localparam logic [7:0] FT_ARITH = 8'h03;
  localparam logic [7:0] FT_CONSTR = 8'h05;
  localparam logic [7:0] FT_PROT = 8'h07;
  localparam logic [7:0] FT_PARALLEL = 8'h08;
  localparam logic [7:0] FT_TYPE = 8'h0A;
  localparam logic [7:0] FT_OVERRIDE = 8'h10;
  localparam logic [1:0] DEPTH_NORMAL = 2'h0;
  localparam logic [1:0] DEPTH_FIRST = 2'h1;
  localparam logic [1:0] DEPTH_OVR = 2'h2;
  localparam logic [1:0] DEPTH_SYSERR = 2'h3;
  localparam logic [3:0] SYNC_DRAIN_CYC = 4'h4;  // cycles to drain earlier instructions
  typedef enum logic [3:0] {
    ST_IDLE, ST_SYNC, ST_SWITCH, ST_RECORD, ST_HANDLER, ST_IRQ, ST_RUN, ST_RETURN, ST_TRACE, ST_SYSERR
  } fdu_state_type;
endpackage : fdu_pkg

// file: rtl/fdu_rec_mem.sv
// small fault record store with registered read data
`timescale 1ns/10ps
`default_nettype none
module fdu_rec_mem
  import fdu_pkg::*;
(
  input wire logic clk,
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [31:0] wdata,
  input wire logic [3:0] raddr,
  output logic [31:0] rdata
);
  logic [31:0] mem [0:15];  // record words below the new frame pointer
  // write and registered read
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : fdu_rec_mem
`default_nettype wire

// file: rtl/fdu_sync.sv
// three-stage synchroniser for a pin level
`timescale 1ns/10ps
`default_nettype none
module fdu_sync
(
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  // change accepted once second and third stage agree
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
      begin
        dout <= s3_r;
      end
    end
  end
endmodule : fdu_sync
`default_nettype wire

// file: rtl/fdu_fault_dispatch.sv
// fault dispatch unit: supervisor fault calls, overrides and system error
//
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module fdu_fault_dispatch
  import fdu_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic fault_pin,
  input wire logic irq_pin,
  output logic fail_n,
  output logic [31:0] addr_bus,
  output logic user_mode,
  output logic in_handler
);
  import fdu_pkg::*;

  // bus address phase capture
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic rd_pend_r;
  logic [7:0] rd_addr_r;
  wire addr_ok = hsel && hready && htrans[1];
  // software visible state
  logic [31:0] ctrl_r;
  logic [31:0] fault_r;      // [7:0] type, [15:8] subtype, [16] imprecise, [17] concurrent
  logic [31:0] fdata_r;
  logic [31:0] ssp_r;
  logic [31:0] hip_r;
  logic [31:0] fp_r;
  logic [31:0] ac_r;         // arith_controls_reg
  logic [31:0] pc_r;         // process_controls_reg
  logic [31:0] saved_ac_r;
  logic [31:0] saved_pc_r;
  logic [31:0] saved_fp_r;
  logic [31:0] new_frame_pointer_r;
  logic [31:0] pfp_r;        // previous frame pointer with return type in low bits
  logic [31:0] return_ip_r;
  logic [7:0] ovr_type_r;    // override_fault_type
  logic [7:0] ovr_sub_r;     // override_fault_subtype
  logic [15:0] ovr_data_r;
  logic [1:0] depth_r;
  logic fault_go_r;
  logic ret_go_r;
  logic precise_r;
  logic parallel_r;
  logic irq_taken_r;
  logic [3:0] cnt_r;
  logic [3:0] widx_r;
  fdu_state_type state_r;
  fdu_state_type state_nxt;
  logic fail_n_r;
  logic in_handler_r;  // handler running, registered so the pin is glitch free
  logic [31:0] addr_bus_r;
  // pin side synchronisers
  logic fault_s;
  logic irq_s;
  logic fault_s_d_r;
  fdu_sync u_fault_sync (.clk(clk), .rst(rst), .din(fault_pin), .dout(fault_s));
  fdu_sync u_irq_sync (.clk(clk), .rst(rst), .din(irq_pin), .dout(irq_s));
  wire second_fault = fault_s && !fault_s_d_r;  // rising edge of a nested fault

  // record memory
  logic [31:0] rec_rdata;
  logic rec_we;
  logic [31:0] rec_wdata;
  fdu_rec_mem u_rec (.clk(clk), .we(rec_we), .waddr(widx_r), .wdata(rec_wdata),
                     .raddr(4'h0), .rdata(rec_rdata));

  // fault classification
  wire [7:0] ftype = fault_r[7:0];
  wire always_precise = (ftype == FT_TRACE) || (ftype == FT_PROT);
  wire may_imprecise = (ftype == FT_OPER) || (ftype == FT_CONSTR) || (ftype == FT_ARITH) ||
                       (ftype == FT_TYPE);
  wire nif = ctrl_r[CTRL_NIF];
  // precise when forced by class, by the nif bit, or when reported clean and in order
  wire is_precise = always_precise || nif || !fault_r[16] || !may_imprecise;
  wire is_parallel = !is_precise && fault_r[17] && !nif;
  wire no_te_copy = (ftype == FT_TRACE) || is_parallel || (depth_r == DEPTH_OVR);
  wire [31:0] frame_base = ctrl_r[CTRL_USER] ? ssp_r : fp_r;
  wire [31:0] nfp_calc = frame_base + RECORD_SIZE;
  wire [3:0] rec_last = 4'h5;
  // record words: type, data, ac, pc, return ip, override info
  assign rec_we = (state_r == ST_RECORD);
  assign rec_wdata = (widx_r == 4'h0) ? fault_r :
                     (widx_r == 4'h1) ? fdata_r :
                     (widx_r == 4'h2) ? ac_r :
                     (widx_r == 4'h3) ? pc_r :
                     (widx_r == 4'h4) ? return_ip_r :
                     {ovr_data_r, ovr_sub_r, ovr_type_r};
  // read mux
  wire [31:0] rd_mux =
    (rd_addr_r == OFF_CTRL) ? ctrl_r :
    (rd_addr_r == OFF_FAULT) ? fault_r :
    (rd_addr_r == OFF_SSP) ? ssp_r :
    (rd_addr_r == OFF_HIP) ? hip_r :
    (rd_addr_r == OFF_FP) ? fp_r :
    // status also shows the return type last written into the previous frame pointer
    (rd_addr_r == OFF_STATUS) ? {18'h00000, pfp_r[2:0], state_r, parallel_r, precise_r, irq_taken_r,
                                 depth_r, 2'h0} :
    (rd_addr_r == OFF_NFP) ? new_frame_pointer_r :
    (rd_addr_r == OFF_REC) ? rec_rdata :
    (rd_addr_r == OFF_OVR) ? {ovr_data_r, ovr_sub_r, ovr_type_r} :
    (rd_addr_r == OFF_ACPC) ? {ac_r[15:0], pc_r[15:0]} :
    (rd_addr_r == OFF_ERRADDR) ? addr_bus_r :
    32'h00000000;

  // next state
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (fault_go_r) state_nxt = ST_SYNC;
        else if (ret_go_r) state_nxt = ST_SYNC;
      ST_SYNC:
        if (cnt_r == 4'h0) state_nxt = ret_go_r ? ST_RETURN : ST_SWITCH;
      ST_SWITCH:
        state_nxt = ST_RECORD;
      ST_RECORD:
        if (second_fault && depth_r == DEPTH_OVR) state_nxt = ST_SYSERR;
        else if (second_fault && !is_parallel) state_nxt = ST_SWITCH;
        else if (second_fault) state_nxt = ST_SYSERR;
        else if (widx_r == rec_last) state_nxt = ST_HANDLER;
      ST_HANDLER:
        state_nxt = (irq_s || irq_taken_r) ? ST_IRQ : ST_RUN;
      ST_IRQ:
        if (!irq_s) state_nxt = ST_RUN;
      ST_RUN:
        if (ret_go_r) state_nxt = ST_SYNC;
      ST_RETURN:
        state_nxt = (saved_pc_r[PC_TFP] && saved_pc_r[TRACE_ENABLE_BIT]) ? ST_TRACE : ST_IDLE;
      ST_TRACE:
        state_nxt = ST_IDLE;
      ST_SYSERR:
        state_nxt = ST_SYSERR;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // bus slave: wait-free write data phase, read data phase with one wait state, always okay
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rd_addr_r <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      wr_pend_r <= addr_ok && hwrite;
      rd_pend_r <= addr_ok && !hwrite;
      wr_addr_r <= haddr[7:0];
      if (addr_ok && !hwrite)
      begin
        rd_addr_r <= haddr[7:0];
      end
      hreadyout <= !(addr_ok && !hwrite);  // one wait state so read data comes from a flop
      if (rd_pend_r)
      begin
        hrdata <= rd_mux;
      end
    end
  end

  // dispatch engine and register writes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      ctrl_r <= 32'h00000002;
      fault_r <= 32'h00000000;
      fdata_r <= 32'h00000000;
      ssp_r <= 32'h00000000;
      hip_r <= 32'h00000000;
      fp_r <= 32'h00000000;
      ac_r <= 32'h00000000;
      pc_r <= 32'h00000004;
      saved_ac_r <= 32'h00000000;
      saved_pc_r <= 32'h00000000;
      saved_fp_r <= 32'h00000000;
      new_frame_pointer_r <= 32'h00000000;
      pfp_r <= 32'h00000000;
      return_ip_r <= 32'h00000000;
      ovr_type_r <= 8'h00;
      ovr_sub_r <= 8'h00;
      ovr_data_r <= 16'h0000;
      depth_r <= DEPTH_NORMAL;
      fault_go_r <= 1'b0;
      ret_go_r <= 1'b0;
      precise_r <= 1'b0;
      parallel_r <= 1'b0;
      irq_taken_r <= 1'b0;
      cnt_r <= 4'h0;
      widx_r <= 4'h0;
      fault_s_d_r <= 1'b0;
      fail_n_r <= 1'b1;
      addr_bus_r <= 32'h00000000;
      in_handler_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      // follows the state register exactly, one flop instead of a decode on the pin
      in_handler_r <= (state_nxt == ST_RUN);
      fault_s_d_r <= fault_s;
      // software writes
      if (wr_pend_r && state_r != ST_SYSERR)
      begin
        if (wr_addr_r == OFF_CTRL)
        begin
          ctrl_r <= hwdata;
          // mode only follows software between calls, never in the middle of one
          if (state_r == ST_IDLE) pc_r[PC_USER] <= hwdata[CTRL_USER];
        end
        else if (wr_addr_r == OFF_FAULT && state_r == ST_IDLE)
        begin
          fault_r <= hwdata;
          fault_go_r <= 1'b1;
        end
        else if (wr_addr_r == OFF_SSP) ssp_r <= hwdata;
        else if (wr_addr_r == OFF_HIP) hip_r <= hwdata;
        else if (wr_addr_r == OFF_FP) fp_r <= hwdata;
        else if (wr_addr_r == OFF_RET && state_r == ST_RUN) ret_go_r <= 1'b1;
      end
      ac_r[CTRL_NIF] <= ctrl_r[CTRL_NIF];
      // interrupt arriving mid-dispatch is remembered until the handler entry
      if (irq_s && state_r != ST_IDLE && state_r != ST_RUN) irq_taken_r <= 1'b1;
      case (state_r)
        ST_IDLE:
        begin
          cnt_r <= SYNC_DRAIN_CYC;  // implicit sync before call or return
          if (fault_go_r) depth_r <= DEPTH_FIRST;
        end
        ST_SYNC:
          cnt_r <= cnt_r - 4'h1;
        ST_SWITCH:
        begin
          fault_go_r <= 1'b0;
          precise_r <= is_precise;
          parallel_r <= is_parallel;
          saved_fp_r <= fp_r;
          saved_ac_r <= ac_r;
          saved_pc_r <= pc_r;
          new_frame_pointer_r <= nfp_calc;
          widx_r <= 4'h0;
          pc_r[PC_USER] <= 1'b0;
          pfp_r <= {fp_r[31:3], FAULT_RET_CODE};
        end
        ST_RECORD:
        begin
          widx_r <= widx_r + 4'h1;
          if (second_fault && depth_r == DEPTH_FIRST && !is_parallel)
          begin
            depth_r <= DEPTH_OVR;
            ovr_type_r <= fdata_r[7:0];
            ovr_sub_r <= fdata_r[15:8];
            ovr_data_r <= fdata_r[31:16];
          end
          else if (second_fault)
          begin
            depth_r <= DEPTH_SYSERR;
          end
        end
        ST_HANDLER:
        begin
          return_ip_r <= hip_r;
          fp_r <= new_frame_pointer_r;
          if (no_te_copy) pc_r[TRACE_ENABLE_BIT] <= 1'b0;
          else pc_r[TRACE_ENABLE_BIT] <= ctrl_r[CTRL_TTRACE];
          depth_r <= DEPTH_NORMAL;
        end
        ST_IRQ:
          irq_taken_r <= 1'b0;
        ST_RUN:
          cnt_r <= SYNC_DRAIN_CYC;  // return drains as long as the call did
        ST_RETURN:
        begin
          ret_go_r <= 1'b0;
          ac_r <= saved_ac_r;
          if (!pc_r[PC_USER]) pc_r <= saved_pc_r;
          fp_r <= saved_fp_r;
        end
        ST_TRACE:
          fault_r <= {24'h000000, FT_TRACE};
        ST_SYSERR:
        begin
          fail_n_r <= 1'b0;
          addr_bus_r <= SYS_ERR_ADDR;
        end
        default:
          cnt_r <= 4'h0;
      endcase
    end
  end

  // outputs straight from flops
  assign fail_n = fail_n_r;
  assign addr_bus = addr_bus_r;
  assign user_mode = pc_r[PC_USER];
  assign in_handler = in_handler_r;
endmodule : fdu_fault_dispatch
`default_nettype wire

// file: tb/fdu_fault_dispatch_props.sv
// port-level checker for the fault dispatch unit, bound to its top module
`timescale 1ns/10ps
`default_nettype none
module fdu_fault_dispatch_props
  import fdu_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic fail_n,
  input wire logic [31:0] addr_bus,
  input wire logic user_mode,
  input wire logic in_handler
);
  // all checks live in the one core clock domain
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  wire logic take_rd; // read address phase accepted
  wire logic take_wr; // write address phase accepted
  assign take_rd = hsel && hready && htrans[1] && !hwrite;
  assign take_wr = hsel && hready && htrans[1] && hwrite;
  a_err_addr: assert property (!fail_n |-> addr_bus == SYS_ERR_ADDR)
    else $error("error address missing while failed");
  a_fail_sticky: assert property (!fail_n |=> !fail_n)
    else $error("failure indicator released without reset");
  a_err_steady: assert property (!fail_n |=> $stable(addr_bus))
    else $error("address bus moved in system error");
  a_err_quiet: assert property (!fail_n |-> !in_handler)
    else $error("handler running in system error");
  a_super_mode: assert property (in_handler |-> !user_mode)
    else $error("handler running in user mode");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  // reads stall exactly one cycle, so hready must come back on the second edge
  a_rd_wait: assert property (take_rd |=> !hreadyout ##1 hreadyout)
    else $error("read data phase length wrong");
  a_wr_ready: assert property (take_wr |=> hreadyout)
    else $error("write data phase stalled");
endmodule : fdu_fault_dispatch_props
bind fdu_fault_dispatch fdu_fault_dispatch_props u_fdu_fault_dispatch_props (.clk(clk), .rst(rst), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .fail_n(fail_n),
  .addr_bus(addr_bus), .user_mode(user_mode), .in_handler(in_handler));
`default_nettype wire

// file: tb/fault_dispatch_unit_bench.sv
// self-checking testbench for the fault dispatch unit
`timescale 1ns/10ps
`default_nettype none
module fault_dispatch_unit_bench;
  import fdu_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2; // whole words only
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic fault_pin = 1'b0;
  logic irq_pin = 1'b0;
  logic fail_n;
  logic [31:0] addr_bus;
  logic user_mode;
  logic in_handler;
  logic [31:0] exp_q[$]; // expected read data, oldest first
  logic rd_pend = 1'b0; // a read data phase is open
  int n_errors = 0;
  int cmp_count = 0;
  int seed = 83;
  int i;
  logic [31:0] r;
  logic [7:0] kind;
  logic [7:0] kinds[6] = '{FT_TRACE, FT_PROT, FT_OPER, FT_ARITH, FT_CONSTR, FT_TYPE};
  // single slave, so its ready is the bus ready
  assign hready = hreadyout;
  fdu_fault_dispatch u_fdu_fault_dispatch (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .fault_pin(fault_pin), .irq_pin(irq_pin), .fail_n(fail_n), .addr_bus(addr_bus),
    .user_mode(user_mode), .in_handler(in_handler));
  // 10 MHz core clock
  initial
  begin
    forever #50 clk = ~clk;
  end
  task complete_run();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  task check(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  // bounded wait, sampled mid-cycle where every register has settled
  task wait_for(input int sel, input logic v);
    int k;
    for (k = 0; k < 300; k++)
    begin
      @(negedge clk);
      if (((sel == 0) ? in_handler : (sel == 1) ? fail_n : (sel == 2) ? user_mode : hreadyout) === v)
        break;
    end
    if (k == 300)
    begin
      n_errors++;
      $display("[ERR] wait %0d expected %b seen timeout", sel, v);
      complete_run();
    end
  endtask : wait_for
  // one single transfer: address phase held until ready, then data phase held until ready
  task xfer(input logic wr_en, input logic [7:0] off, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, off};
    hwrite <= wr_en;
    wait_for(3, 1'b1);
    @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_for(3, 1'b1);
    @(posedge clk);
  endtask : xfer
  task wr(input logic [7:0] off, input logic [31:0] d);
    xfer(1'b1, off, d);
  endtask : wr
  task rd(input logic [7:0] off, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, off, 32'h0);
  endtask : rd
  // read data watcher: a read result appears when its data phase ends with ready high
  always @(posedge clk)
  begin
    if (rd_pend && hreadyout && exp_q.size() > 0)
      check("hrdata", exp_q.pop_front(), hrdata);
    if (rd_pend && hreadyout)
      rd_pend = 1'b0;
    if (!rst && hsel && hready && htrans[1] && !hwrite)
      rd_pend = 1'b1;
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("fail_n", 32'h1, {31'h0, fail_n});
    rd(OFF_ERRADDR, 32'h0);
    wr(8'h3C, 32'hFFFFFFFF); // unmapped place, must be dropped
    wr(OFF_RET, 32'h1); // return while idle is refused
    @(negedge clk);
    check("in_handler", 32'h0, {31'h0, in_handler});
    $display("reset and refusals done");
    // six fault kinds (not parallel or override), first from user mode then from supervisor mode
    for (i = 0; i < 12; i++)
    begin
      r = $random(seed);
      kind = kinds[i % 6];
      wr(OFF_SSP, r & 32'hFFFFFFF0);
      wr(OFF_FP, ~r & 32'hFFFFFFF0);
      wr(OFF_HIP, {r[15:0], r[31:18], 2'h0});
      wr(OFF_CTRL, {29'h0, r[2], (i < 6), r[0]});
      irq_pin <= r[5];
      wr(OFF_FAULT, {15'h0, r[3] && kind != FT_TRACE && kind != FT_PROT, r[15:8], kind});
      irq_pin <= 1'b0;
      wait_for(0, 1'b1);
      check("user_mode", 32'h0, {31'h0, user_mode});
      rd(OFF_NFP, ((i < 6) ? (r & 32'hFFFFFFF0) : (~r & 32'hFFFFFFF0)) + RECORD_SIZE);
      wr(OFF_RET, 32'h0);
      wait_for(0, 1'b0);
      wait_for(2, (i < 6));
      check("user_mode", {31'h0, (i < 6)}, {31'h0, user_mode});
      // the frame pointer comes back only after the return drain
      repeat (int'(SYNC_DRAIN_CYC) + 4) @(posedge clk);
      rd(OFF_FP, ~r & 32'hFFFFFFF0);
    end
    $display("fault calls and returns done");
    // two further faults during dispatch: override, then system error
    wr(OFF_CTRL, 32'h2);
    wr(OFF_FAULT, {24'h0, FT_ARITH});
    for (i = 0; i < 10; i++)
    begin
      @(posedge clk);
      fault_pin <= (i == 2 || i == 3 || i == 6 || i == 7);
    end
    wait_for(1, 1'b0);
    check("addr_bus", SYS_ERR_ADDR, addr_bus);
    wr(OFF_CTRL, 32'h3); // writes are dropped in system error
    rd(OFF_ERRADDR, SYS_ERR_ADDR);
    @(negedge clk);
    check("fail_n", 32'h0, {31'h0, fail_n});
    $display("nested faults done");
    complete_run();
  end
endmodule : fault_dispatch_unit_bench
`default_nettype wire
